// ---- rtl/pdrs_sequencer.sv ----
/*
 * Power-down and reset sequencer: enters power-down on halt with the
 * enable bit set, leaves on the wake request (after the capacitor delay)
 * or on reset, gates the core clock, latches and serves the wake request.
 * Assumes all inputs synchronous to clk; the capacitor pin is resolved
 * from its output enable outside this module.
 */
`timescale 1ns/1ps

// How it works
// [R01] Power-down starts only on a halt while the enable bit is one.
// [R02] Power-down ends on the wake request or on the reset input.
// [R03] A wake by request waits for the capacitor pin before clocks return.
// [R04] A wake by reset skips the capacitor delay entirely.
// [R05] Reset aborts the bus cycle at once and reinitialises all state.
// [R06] During reset every output is defined and the reset indicator is high.
// [R07] The reset indicator stays high while the reset input stays low.
// [R08] A wake request pulse is latched so a short pulse is never lost.
// [R09] A wake request is served as type 2 once clocks run again.
// [R10] Core clocks stay stopped throughout power-down until the exit sequence.
module pdrs_sequencer
(
    // Clock and reset input
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Core control
    input  wire logic       powerdown_enable_bit,
    input  wire logic       haltExec,
    output logic            clockEnable,
    output logic            powerdownActive,
    output logic            busAbort,
    output logic            resetIndicator,
    // Wake request and its service
    input  wire logic       nmiIn,
    input  wire logic       nmiAck,
    output logic            nmiServiceReq,
    output logic [7:0]      nmiType,
    // Capacitor timing pin
    input  wire logic       wakeTimerIn,
    output logic            wakeTimerOut,
    output logic            wakeTimerOe
);

    // ==========================================================
    // Internal state
    pdrs_pkg::pdrs_state_t state_reg;
    pdrs_pkg::pdrs_state_t state_next;
    logic                  nmiLatch_reg;
    logic                  wakeCause;

    assign wakeCause = nmiIn | nmiLatch_reg;

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pdrs_pkg::PDRS_RUN:
            begin
                // [R01] halt with enable
                if (haltExec && powerdown_enable_bit)
                    state_next = pdrs_pkg::PDRS_PDOWN;
            end
            pdrs_pkg::PDRS_PDOWN:
            begin
                // [R02] wake by request
                if (wakeCause)
                    state_next = pdrs_pkg::PDRS_WAKE;
            end
            pdrs_pkg::PDRS_WAKE:
            begin
                // [R03] wait for capacitor
                if (wakeTimerIn)
                    state_next = pdrs_pkg::PDRS_RUN;
            end
            default:
                state_next = pdrs_pkg::PDRS_RUN;
        endcase
    end

    // ==========================================================
    // State register; reset returns straight to run, no delay
    always_ff @(posedge clk)
    begin
        // [R04] reset bypasses wake
        if (!rst_b)
            state_reg <= pdrs_pkg::PDRS_RUN;
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // Clock gate and status, registered from the next state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            clockEnable     <= pdrs_pkg::PDRS_CLKEN_RST;
            powerdownActive <= 1'h0;
        end
        else
        begin
            // [R10] clocks stopped off run
            clockEnable     <= (state_next == pdrs_pkg::PDRS_RUN);
            powerdownActive <= (state_next != pdrs_pkg::PDRS_RUN);
        end
    end

    // ==========================================================
    // Reset indicator and bus abort follow the reset input
    always_ff @(posedge clk)
    begin
        // [R05] abort and reinitialise
        // [R07] indicator tracks reset
        if (!rst_b)
        begin
            busAbort       <= pdrs_pkg::PDRS_ABORT_RST;
            resetIndicator <= pdrs_pkg::PDRS_RESIND_RST;
        end
        else
        begin
            busAbort       <= 1'h0;
            resetIndicator <= 1'h0;
        end
    end

    // ==========================================================
    // Wake request latch; a new request beats a same-cycle ack
    always_ff @(posedge clk)
    begin
        // [R08] latch short pulses
        if (!rst_b)
            nmiLatch_reg <= 1'h0;
        else if (nmiIn)
            nmiLatch_reg <= 1'h1;
        else if (nmiAck)
            nmiLatch_reg <= 1'h0;
    end

    // ==========================================================
    // Service request only while the core clock runs
    always_ff @(posedge clk)
    begin
        // [R09] serve type 2
        if (!rst_b)
        begin
            nmiServiceReq <= pdrs_pkg::PDRS_NMIREQ_RST;
            nmiType       <= pdrs_pkg::PDRS_NMI_TYPE;
        end
        else
        begin
            nmiServiceReq <= wakeCause && !nmiAck && (state_next == pdrs_pkg::PDRS_RUN);
            nmiType       <= pdrs_pkg::PDRS_NMI_TYPE;
        end
    end

    // ==========================================================
    // Capacitor pin: held discharged in power-down, released to charge
    // in wake; released in run so reset never waits on it
    always_ff @(posedge clk)
    begin
        // [R06] pin defined in reset
        if (!rst_b)
        begin
            wakeTimerOe  <= pdrs_pkg::PDRS_TMROE_RST;
            wakeTimerOut <= pdrs_pkg::PDRS_TMROUT_LVL;
        end
        else
        begin
            wakeTimerOe  <= (state_next == pdrs_pkg::PDRS_PDOWN);
            wakeTimerOut <= pdrs_pkg::PDRS_TMROUT_LVL;
        end
    end

    // ==========================================================
    // Checks
    sequence s_enterReq;
        state_reg == pdrs_pkg::PDRS_RUN && haltExec && powerdown_enable_bit;
    endsequence

    sequence s_wakeReady;
        state_reg == pdrs_pkg::PDRS_WAKE && wakeTimerIn;
    endsequence

    sequence s_backToRun;
        state_reg == pdrs_pkg::PDRS_RUN && clockEnable && !powerdownActive;
    endsequence

    a_pd_entry: assert property (@(posedge clk) disable iff (!rst_b) // [R01]
        s_enterReq |=> state_reg == pdrs_pkg::PDRS_PDOWN && !clockEnable)
        else $error("power-down not entered on halt");

    a_pd_only: assert property (@(posedge clk) disable iff (!rst_b) // [R01]
        state_reg == pdrs_pkg::PDRS_RUN && !(haltExec && powerdown_enable_bit)
        |=> state_reg == pdrs_pkg::PDRS_RUN)
        else $error("power-down entered without cause");

    a_wake_exit: assert property (@(posedge clk) disable iff (!rst_b) // [R02]
        state_reg == pdrs_pkg::PDRS_PDOWN && nmiIn |=> state_reg == pdrs_pkg::PDRS_WAKE)
        else $error("wake request did not leave power-down");

    a_wake_delay: assert property (@(posedge clk) disable iff (!rst_b) // [R03]
        state_reg == pdrs_pkg::PDRS_WAKE && !wakeTimerIn |=> !clockEnable)
        else $error("clocks resumed before capacitor delay");

    a_wake_done: assert property (@(posedge clk) disable iff (!rst_b) // [R03]
        s_wakeReady |=> s_backToRun)
        else $error("clocks not resumed after delay");

    a_reset_run: assert property (@(posedge clk) // [R04]
        !rst_b |=> state_reg == pdrs_pkg::PDRS_RUN && clockEnable && !wakeTimerOe)
        else $error("reset did not restore run at once");

    a_reset_abort: assert property (@(posedge clk) // [R05]
        !rst_b |=> busAbort && !nmiServiceReq && !nmiLatch_reg)
        else $error("reset did not abort and clear");

    a_reset_hold: assert property (@(posedge clk) // [R07]
        !rst_b ##1 !rst_b |=> resetIndicator [*1])
        else $error("reset indicator dropped during reset");

    a_reset_release: assert property (@(posedge clk) // [R06]
        !rst_b ##1 rst_b |=> !resetIndicator && !busAbort)
        else $error("reset indicator stuck after release");

    a_nmi_latch: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
        nmiIn |=> nmiLatch_reg)
        else $error("wake request not latched");

    a_nmi_serve: assert property (@(posedge clk) disable iff (!rst_b) // [R09]
        nmiServiceReq |-> clockEnable && nmiType == pdrs_pkg::PDRS_NMI_TYPE)
        else $error("wake request served without clocks or wrong type");

    a_clk_stop: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        state_reg != pdrs_pkg::PDRS_RUN |-> !clockEnable && powerdownActive)
        else $error("clock running during power-down");

endmodule : pdrs_sequencer

// ---- rtl/pdrs_pkg.sv ----
/*
 * Shared constants for the power-down and reset sequencer.
 * Assumes one 10 MHz clock and a synchronous active-low reset.
 */
package pdrs_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        PDRS_RUN   = 2'h0,
        PDRS_PDOWN = 2'h1,
        PDRS_WAKE  = 2'h2
    } pdrs_state_t;

    // ==========================================================
    // Interrupt type served for the wake request
    localparam logic [7:0] PDRS_NMI_TYPE = 8'h02;

    // ==========================================================
    // Reset values of the outputs
    localparam logic PDRS_CLKEN_RST   = 1'h1;
    localparam logic PDRS_RESIND_RST  = 1'h1;
    localparam logic PDRS_ABORT_RST   = 1'h1;
    localparam logic PDRS_NMIREQ_RST  = 1'h0;
    localparam logic PDRS_TMROE_RST   = 1'h0;
    localparam logic PDRS_TMROUT_LVL  = 1'h0;

endpackage : pdrs_pkg

// ---- verification/pdrs_cap_model.sv ----
/* Capacitor model on the wake delay pin.
   Assumes the device discharges it through wakeTimerOe. */
`timescale 1ns/1ps
module pdrs_cap_model
(
    // Clock
    input  wire logic       clk,
    // Pin side
    input  wire logic       wakeTimerOut,
    input  wire logic       wakeTimerOe,
    input  wire logic [7:0] chargeCycles,
    output logic            pinLevel
);
    logic [7:0] chargeCnt = 8'hFF;
    // ==========================================
    // Charge ramp; saturates so the pin stays high
    always_ff @(posedge clk)
    begin
        if (wakeTimerOe)
            chargeCnt <= 8'h00;
        else if (chargeCnt != 8'hFF)
            chargeCnt <= chargeCnt + 8'h01;
    end
    assign pinLevel = wakeTimerOe ? wakeTimerOut : (chargeCnt >= chargeCycles);
endmodule : pdrs_cap_model

// ---- verification/pdrs_sequencer_tb.sv ----
/* Self-checking bench for the power-down and reset sequencer.
   Assumes the capacitor model and a 10 MHz clock. */
`timescale 1ns/1ps
module pdrs_sequencer_tb;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       enBit = 1'b0;
    logic       haltExec = 1'b0;
    logic       nmiIn = 1'b0;
    logic       nmiAck = 1'b0;
    logic [7:0] chargeCycles = 8'h10;
    logic       clockEnable, powerdownActive, busAbort, resetIndicator, en;
    logic       nmiServiceReq, wakeTimerOut, wakeTimerOe, pinLevel, seenHigh;
    logic [7:0] nmiType;
    int         errors = 0;
    int         n_compared = 0;
    int         waitCnt;
    pdrs_sequencer uut (.clk(clk), .rst_b(rst_b), .powerdown_enable_bit(enBit),
        .haltExec(haltExec), .clockEnable(clockEnable), .powerdownActive(powerdownActive),
        .busAbort(busAbort), .resetIndicator(resetIndicator), .nmiIn(nmiIn),
        .nmiAck(nmiAck), .nmiServiceReq(nmiServiceReq), .nmiType(nmiType),
        .wakeTimerIn(pinLevel), .wakeTimerOut(wakeTimerOut), .wakeTimerOe(wakeTimerOe));
    pdrs_cap_model cap (.clk(clk), .wakeTimerOut(wakeTimerOut), .wakeTimerOe(wakeTimerOe),
        .chargeCycles(chargeCycles), .pinLevel(pinLevel));
    // ==========================================
    // Clock and helpers
    always #50 clk = ~clk;
    function automatic logic pdExpected(input logic enable, input logic halt);
        return enable & halt;
    endfunction : pdExpected
    task automatic chkBit(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chkBit
    task automatic chkByte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chkByte
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic ack_nmi();
        nmiAck = 1'b1;
        cyc(1);
        nmiAck = 1'b0;
        chkBit("nmiServiceReq", 1'b0, nmiServiceReq);
    endtask : ack_nmi
    // Short wake pulse; clocks must wait for the charged pin
    task automatic wake_by_nmi();
        nmiIn = 1'b1;
        cyc(1);
        nmiIn = 1'b0;
        seenHigh = 1'b0;
        waitCnt = 0;
        while (clockEnable !== 1'b1 && waitCnt < 300)
        begin
            seenHigh = seenHigh | pinLevel;
            cyc(1);
            waitCnt++;
        end
        chkBit("clockEnable", 1'b1, clockEnable);
        chkBit("pinChargedFirst", 1'b1, seenHigh);
        chkBit("powerdownActive", 1'b0, powerdownActive);
        chkBit("nmiServiceReq", 1'b1, nmiServiceReq);
        chkByte("nmiType", 8'h02, nmiType);
        ack_nmi();
    endtask : wake_by_nmi
    // Reset exit never waits on the pin
    task automatic wake_by_reset();
        rst_b = 1'b0;
        repeat ($urandom_range(4, 1))
        begin
            cyc(1);
            chkBit("resetIndicator", 1'b1, resetIndicator);
            chkBit("clockEnable", 1'b1, clockEnable);
        end
        chkBit("busAbort", 1'b1, busAbort);
        chkBit("powerdownActive", 1'b0, powerdownActive);
        chkBit("wakeTimerOe", 1'b0, wakeTimerOe);
        chkBit("wakeTimerOut", 1'b0, wakeTimerOut);
        rst_b = 1'b1;
        cyc(1);
        chkBit("resetIndicator", 1'b0, resetIndicator);
        chkBit("busAbort", 1'b0, busAbort);
    endtask : wake_by_reset
    // ==========================================
    // Main sequence
    initial
    begin
        waitCnt = $urandom(32'h2355f762);
        cyc(10);
        chkBit("resetIndicator", 1'b1, resetIndicator);
        chkBit("nmiServiceReq", 1'b0, nmiServiceReq);
        rst_b = 1'b1;
        cyc(1);
        chkBit("resetIndicator", 1'b0, resetIndicator);
        chkBit("busAbort", 1'b0, busAbort);
        nmiIn = 1'b1;
        cyc(1);
        nmiIn = 1'b0;
        cyc(2);
        chkBit("nmiServiceReq", 1'b1, nmiServiceReq);
        ack_nmi();
        // Request and ack in one cycle: the new request must survive
        cyc(1);
        nmiIn = 1'b1;
        nmiAck = 1'b1;
        cyc(1);
        nmiIn = 1'b0;
        nmiAck = 1'b0;
        cyc(1);
        chkBit("nmiServiceReq", 1'b1, nmiServiceReq);
        ack_nmi();
        for (int i = 0; i < 10; i++)
        begin
            chargeCycles = 8'($urandom_range(40, 3));
            // First pass refused, then one reset exit and one request exit for sure
            if (i == 0)
                en = 1'b0;
            else if (i <= 2)
                en = 1'b1;
            else
                en = 1'($urandom_range(1, 0));
            enBit = en;
            haltExec = 1'b1;
            cyc(1);
            haltExec = 1'b0;
            chkBit("powerdownActive", pdExpected(en, 1'b1), powerdownActive);
            chkBit("clockEnable", ~pdExpected(en, 1'b1), clockEnable);
            chkBit("wakeTimerOe", pdExpected(en, 1'b1), wakeTimerOe);
            if (en && (i == 1 || (i > 2 && $urandom_range(2, 0) == 0)))
                wake_by_reset();
            else if (en)
                wake_by_nmi();
            cyc(2);
        end
        report_and_stop();
    end
    // Watchdog well beyond the worst-case run
    initial
    begin
        #1000000;
        errors++;
        report_and_stop();
    end
endmodule : pdrs_sequencer_tb
